// ==== pkg/mstc_pkg.sv ====
// Summary of operation
// RL1: Column strobe plays three 32-bit waveform words, bit 0 with row strobe assertion.
// RL2: Each waveform bit lasts one CPU cycle, or two when half-rate set.
// RL3: Mid word follows low word, high word follows mid, one sequence.
// RL4: Bit one holds column strobe high; bit zero drives it low.
// RL5: Count column pulses; release row strobe the cycle after the eighth ends.
// RL6: Software must encode all eight pulses, else the burst hangs.
// RL7: Full rate: lowest four bits one, each strobe level at least two cycles.
// RL8: Half rate: lowest two bits one, each strobe level at least one bit.
// RL9: Waveform words keep their contents through reset.
// RL10: Four static fields, two per register, per chip select, memory-clock timing.
// RL11: Reset loads bank zero field with slowest ROM pattern, width from pin.
// RL12: Type field: 00 ROM/Flash, 01 ROM/SRAM, 10 burst four, 11 burst eight.
// RL13: Width bit two: zero selects 32-bit bus, one selects 16-bit bus.
// RL14: First-access delay is field plus one plus one memory clock.
// RL15: Next-access delay and write pulse is field plus one plus one.
// RL16: After reads, recovery holds other banks and row strobe twice field clocks.
// RL17: Flash and SRAM banks also recover after writes before any access.
// RL18: Type 01 banks drive byte mask on the four column strobe pins.
// RL19: Software uses type 01 only without DRAM attached.
// RL20: Software sizes recovery field for turn-off, write-high and write-to-read.
// RL21: Shifter advances every CPU clock, or every memory clock when half-rate.
// RL22: Waveform and static registers read back the last written value.
`default_nettype none
package mstc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_WAVE_LO = 8'h00;
    localparam logic [7:0] OFF_WAVE_MID = 8'h04;
    localparam logic [7:0] OFF_WAVE_HI = 8'h08;
    localparam logic [7:0] OFF_BANK_LO = 8'h0C;
    localparam logic [7:0] OFF_BANK_HI = 8'h10;
    localparam logic [7:0] OFF_DRAM_CFG = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    // Field positions within a 16-bit bank field; HALF_BIT is in the DRAM config register
    localparam int TYPE_LSB = 0;
    localparam int WIDTH_BIT = 2;
    localparam int FIRST_LSB = 3;
    localparam int NEXT_LSB = 8;
    localparam int REC_LSB = 13;
    localparam int HALF_BIT = 6;
    // Reset values
    localparam logic [15:0] BANK0_RST = 16'hFFF8;
    localparam logic CFG_HALF_RST = 1'b0;
    // Counts
    localparam logic [6:0] WAVE_BITS = 7'h60;
    localparam logic [3:0] BURST_PULSES = 4'h8;
    localparam logic [3:0] BEATS_FOUR = 4'h4;
    localparam logic [3:0] BEATS_EIGHT = 4'h8;
    localparam int CPU_PER_MCLK = 2;
    // Memory types
    localparam logic [1:0] TYPE_FLASH = 2'h0;
    localparam logic [1:0] TYPE_SRAM = 2'h1;
    localparam logic [1:0] TYPE_BURST4 = 2'h2;
    localparam logic [1:0] TYPE_BURST8 = 2'h3;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DRAM = 2'b01,
        ST_STAT = 2'b10
    } mstc_state_t;
endpackage
`default_nettype wire

// ==== verilog/mstc_top.sv ====
// The register offsets and the APB interface to the registers were chosen for this implementation.
`default_nettype none
module mstc_top (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Boot width strap
    input wire logic boot_width_pin_i,
    // DRAM burst request
    input wire logic dram_req_i,
    output logic dram_ack_o,
    // Static access request
    input wire logic st_req_i,
    input wire logic [1:0] st_bank_i,
    input wire logic st_write_i,
    input wire logic [3:0] st_byte_en_i,
    output logic st_ack_o,
    output logic st_beat_o,
    output logic bus_width_o,
    // Memory pins
    output logic [3:0] column_strobe_n_o,
    output logic row_strobe_n_o,
    output logic [3:0] static_chip_select_n_o
);

    typedef struct packed {
        mstc_pkg::mstc_state_t st;
        logic [31:0] wave0;
        logic [31:0] wave1;
        logic [31:0] wave2;
        logic [31:0] bank_lo;
        logic [31:0] bank_hi;
        logic half;
        logic [1:0] pin_sync;
        logic [31:0] rdata;
        logic [6:0] idx;
        logic sub;
        logic [3:0] pulses;
        logic [3:0] col_n;
        logic row_n;
        logic [3:0] cs_n;
        logic [6:0] cnt;
        logic [3:0] beats;
        logic [1:0] bank;
        logic wr;
        logic [15:0] fld;
        logic [4:0] rec;
        logic [1:0] rec_bank;
        logic rec_all;
        logic dram_ack;
        logic st_ack;
        logic beat;
    } mstc_regs_t;

    mstc_regs_t s_q;
    mstc_regs_t s_d;
    logic [95:0] wave_all;
    logic [15:0] req_fld;
    logic wr_en;
    logic rd_setup;
    logic mapped;
    logic adv;
    logic st_go;
    logic nb;

    // Select one bank field
    function automatic logic [15:0] bank_field(input logic [31:0] lo,
                                               input logic [31:0] hi,
                                               input logic [1:0] b);
        logic [63:0] all;
        all = {hi, lo};
        return all[b * 16 +: 16];
    endfunction

    // Access time in CPU cycles minus one, from a five-bit delay
    function automatic logic [6:0] delay_cycles(input logic [4:0] f);
        return 7'((7'(f) + 7'd2) * 7'(mstc_pkg::CPU_PER_MCLK) - 7'd1);
    endfunction

    // Beats per read for a type
    function automatic logic [3:0] beats_of(input logic [1:0] t);
        logic [3:0] n;
        n = 4'h1;
        if (t == mstc_pkg::TYPE_BURST4) begin
            n = mstc_pkg::BEATS_FOUR;
        end else if (t == mstc_pkg::TYPE_BURST8) begin
            n = mstc_pkg::BEATS_EIGHT;
        end
        return n;
    endfunction

    assign wave_all = {s_q.wave2, s_q.wave1, s_q.wave0}; // [RL3]
    assign req_fld = bank_field(s_q.bank_lo, s_q.bank_hi, st_bank_i); // [RL10]
    assign wr_en = psel_i && penable_i && pwrite_i;
    assign rd_setup = psel_i && !penable_i;
    assign mapped = (paddr_i[1:0] == 2'b00) && (paddr_i <= mstc_pkg::OFF_STATUS);
    assign adv = !s_q.half || s_q.sub; // [RL2] [RL21]
    assign nb = (s_q.idx < mstc_pkg::WAVE_BITS) ? wave_all[s_q.idx] : 1'b1;
    assign st_go = st_req_i && (s_q.rec == 5'h00 ||
                   (st_bank_i == s_q.rec_bank && !s_q.rec_all)); // [RL16] [RL17]

    always_comb begin
        s_d = s_q;
        s_d.pin_sync = {s_q.pin_sync[0], boot_width_pin_i};
        s_d.dram_ack = 1'b0;
        s_d.st_ack = 1'b0;
        s_d.beat = 1'b0;
        if (s_q.rec != 5'h00) begin
            s_d.rec = s_q.rec - 5'h01;
        end
        // Register writes
        if (wr_en) begin
            unique case (paddr_i)
                mstc_pkg::OFF_WAVE_LO: s_d.wave0 = pwdata_i; // [RL22]
                mstc_pkg::OFF_WAVE_MID: s_d.wave1 = pwdata_i;
                mstc_pkg::OFF_WAVE_HI: s_d.wave2 = pwdata_i;
                mstc_pkg::OFF_BANK_LO: s_d.bank_lo = pwdata_i;
                mstc_pkg::OFF_BANK_HI: s_d.bank_hi = pwdata_i;
                mstc_pkg::OFF_DRAM_CFG: s_d.half = pwdata_i[mstc_pkg::HALF_BIT];
                default: s_d.rdata = s_d.rdata;
            endcase
        end
        // Read data captured in setup
        if (rd_setup) begin
            unique case (paddr_i)
                mstc_pkg::OFF_WAVE_LO: s_d.rdata = s_q.wave0;
                mstc_pkg::OFF_WAVE_MID: s_d.rdata = s_q.wave1;
                mstc_pkg::OFF_WAVE_HI: s_d.rdata = s_q.wave2;
                mstc_pkg::OFF_BANK_LO: s_d.rdata = s_q.bank_lo;
                mstc_pkg::OFF_BANK_HI: s_d.rdata = s_q.bank_hi;
                mstc_pkg::OFF_DRAM_CFG: s_d.rdata =
                    32'(s_q.half) << mstc_pkg::HALF_BIT;
                mstc_pkg::OFF_STATUS: s_d.rdata = {16'h0000, s_q.pulses,
                    3'b000, s_q.rec, s_q.row_n, s_q.st, s_q.rec_all};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
        unique case (s_q.st)
            mstc_pkg::ST_IDLE: begin
                if (dram_req_i && s_q.rec == 5'h00) begin // [RL16]
                    s_d.st = mstc_pkg::ST_DRAM;
                    s_d.row_n = 1'b0;
                    s_d.col_n = {4{s_q.wave0[0]}}; // [RL1] [RL4]
                    s_d.idx = 7'h01;
                    s_d.sub = 1'b0;
                    s_d.pulses = 4'h0;
                end else if (st_go) begin
                    s_d.st = mstc_pkg::ST_STAT;
                    s_d.bank = st_bank_i;
                    s_d.wr = st_write_i;
                    s_d.fld = req_fld;
                    s_d.cs_n = ~(4'h1 << st_bank_i);
                    s_d.beats = st_write_i ? 4'h1 : beats_of(req_fld[1:0]); // [RL12]
                    s_d.cnt = st_write_i ? delay_cycles(req_fld[12:8]) // [RL15]
                                         : delay_cycles(req_fld[7:3]); // [RL14]
                    if (req_fld[1:0] == mstc_pkg::TYPE_SRAM) begin
                        s_d.col_n = ~st_byte_en_i; // [RL18]
                    end
                end
            end
            mstc_pkg::ST_DRAM: begin
                s_d.sub = ~s_q.sub;
                if (s_q.pulses == mstc_pkg::BURST_PULSES) begin
                    s_d.row_n = 1'b1; // [RL5]
                    s_d.col_n = 4'hF;
                    s_d.st = mstc_pkg::ST_IDLE;
                    s_d.dram_ack = 1'b1;
                end else if (adv && s_q.idx < mstc_pkg::WAVE_BITS) begin
                    s_d.col_n = {4{nb}}; // [RL4]
                    s_d.idx = s_q.idx + 7'h01; // [RL3]
                    if (nb && !s_q.col_n[0]) begin
                        s_d.pulses = s_q.pulses + 4'h1; // [RL5]
                    end
                end
            end
            mstc_pkg::ST_STAT: begin
                if (s_q.cnt != 7'h00) begin
                    s_d.cnt = s_q.cnt - 7'h01;
                end else begin
                    s_d.beat = 1'b1;
                    if (s_q.beats > 4'h1) begin
                        s_d.beats = s_q.beats - 4'h1;
                        s_d.cnt = delay_cycles(s_q.fld[12:8]); // [RL15]
                    end else begin
                        s_d.st = mstc_pkg::ST_IDLE;
                        s_d.cs_n = 4'hF;
                        s_d.col_n = 4'hF;
                        s_d.st_ack = 1'b1;
                        if (!s_q.wr || s_q.fld[1] == 1'b0) begin // [RL17]
                            s_d.rec = {s_q.fld[15:13], 2'b00}; // [RL16]
                            s_d.rec_bank = s_q.bank;
                            s_d.rec_all = s_q.wr;
                        end
                    end
                end
            end
            default: s_d.st = mstc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            // Waveform words and other bank fields keep their contents
            s_q.st <= mstc_pkg::ST_IDLE; // [RL9]
            s_q.pin_sync <= s_d.pin_sync;
            s_q.bank_lo[15:0] <= mstc_pkg::BANK0_RST |
                ({15'h0000, ~s_q.pin_sync[1]} << mstc_pkg::WIDTH_BIT); // [RL11]
            s_q.half <= mstc_pkg::CFG_HALF_RST;
            s_q.rdata <= 32'h0000_0000;
            s_q.idx <= 7'h00;
            s_q.sub <= 1'b0;
            s_q.pulses <= 4'h0;
            s_q.col_n <= 4'hF;
            s_q.row_n <= 1'b1;
            s_q.cs_n <= 4'hF;
            s_q.cnt <= 7'h00;
            s_q.beats <= 4'h0;
            s_q.bank <= 2'b00;
            s_q.wr <= 1'b0;
            s_q.fld <= 16'h0000;
            s_q.rec <= 5'h00;
            s_q.rec_bank <= 2'b00;
            s_q.rec_all <= 1'b0;
            s_q.dram_ack <= 1'b0;
            s_q.st_ack <= 1'b0;
            s_q.beat <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata_o = s_q.rdata;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign dram_ack_o = s_q.dram_ack;
    assign st_ack_o = s_q.st_ack;
    assign st_beat_o = s_q.beat;
    assign bus_width_o = s_q.fld[mstc_pkg::WIDTH_BIT]; // [RL13]
    assign column_strobe_n_o = s_q.col_n;
    assign row_strobe_n_o = s_q.row_n;
    assign static_chip_select_n_o = s_q.cs_n;

    // Cycles chip select has been low, for checking
    logic [7:0] cs_cyc_q;
    always_ff @(posedge core_clk_i) begin
        if (rst_i || s_q.cs_n == 4'hF) begin
            cs_cyc_q <= 8'h00;
        end else begin
            cs_cyc_q <= cs_cyc_q + 8'h01;
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence burst_done_s;
        s_q.st == mstc_pkg::ST_DRAM && s_q.pulses == mstc_pkg::BURST_PULSES;
    endsequence

    sequence dram_start_s;
        s_q.st == mstc_pkg::ST_IDLE && dram_req_i && s_q.rec == 5'h00;
    endsequence

    row_release_a: assert property (burst_done_s |=> row_strobe_n_o && dram_ack_o) // [RL5]
        else $error("row strobe not released after eighth pulse");

    first_bit_a: assert property (dram_start_s |=> // [RL1]
        !row_strobe_n_o && column_strobe_n_o == {4{$past(s_q.wave0[0])}})
        else $error("first waveform bit not aligned with row strobe");

    half_hold_a: assert property (s_q.st == mstc_pkg::ST_DRAM && s_q.half && !s_q.sub // [RL2]
        && s_q.pulses != mstc_pkg::BURST_PULSES |=> $stable(column_strobe_n_o))
        else $error("half-rate bit changed after one cycle");

    full_rate_a: assert property (s_q.st == mstc_pkg::ST_DRAM && !s_q.half // [RL4]
        && s_q.pulses != mstc_pkg::BURST_PULSES && s_q.idx < mstc_pkg::WAVE_BITS
        |=> column_strobe_n_o[0] == $past(wave_all[s_q.idx]))
        else $error("column strobe does not follow waveform bit");

    reset_load_a: assert property ($fell(rst_i) |-> // [RL11]
        s_q.bank_lo[15:0] == (mstc_pkg::BANK0_RST |
        ({15'h0000, ~$past(s_q.pin_sync[1])} << mstc_pkg::WIDTH_BIT)))
        else $error("bank zero field not loaded at reset");

    read_time_a: assert property (s_q.st == mstc_pkg::ST_STAT && s_q.cnt == 7'h00 // [RL14]
        && s_q.beats == 4'h1 && !s_q.wr && s_q.fld[1:0] == mstc_pkg::TYPE_FLASH
        |-> cs_cyc_q == 8'(({3'b000, s_q.fld[7:3]} + 8'd2) * 8'd2 - 8'd1))
        else $error("first access time wrong");

    recovery_a: assert property (s_q.rec != 5'h00 |-> row_strobe_n_o) // [RL16]
        else $error("row strobe asserted during recovery");

    other_bank_a: assert property (s_q.rec != 5'h00 && s_q.rec_all |=> // [RL17]
        s_q.st != mstc_pkg::ST_STAT || $past(s_q.st) == mstc_pkg::ST_STAT)
        else $error("access started during write recovery");

    byte_mask_a: assert property (s_q.st == mstc_pkg::ST_IDLE && st_go && !dram_req_i // [RL18]
        && req_fld[1:0] == mstc_pkg::TYPE_SRAM |=>
        column_strobe_n_o == ~$past(st_byte_en_i))
        else $error("byte mask not driven on column strobes");

    readback_a: assert property (wr_en && paddr_i == mstc_pkg::OFF_WAVE_LO |=> // [RL22]
        s_q.wave0 == $past(pwdata_i))
        else $error("waveform word not stored");

    sequence stat_accept_s;
        s_q.st == mstc_pkg::ST_IDLE && st_go && !(dram_req_i && s_q.rec == 5'h00);
    endsequence

    sequence stat_last_s;
        s_q.st == mstc_pkg::ST_STAT && s_q.cnt == 7'h00 && s_q.beats == 4'h1;
    endsequence

    select_bank_a: assert property (stat_accept_s |=> // [RL10]
        static_chip_select_n_o == ~(4'h1 << $past(st_bank_i)))
        else $error("wrong static chip select driven");

    width_out_a: assert property (stat_accept_s |=> // [RL13]
        bus_width_o == $past(req_fld[mstc_pkg::WIDTH_BIT]))
        else $error("bus width not taken from bank field");

    burst_len_a: assert property (stat_accept_s ##0 (!st_write_i // [RL12]
        && req_fld[1:0] == mstc_pkg::TYPE_BURST8) |=> s_q.beats == mstc_pkg::BEATS_EIGHT)
        else $error("burst of eight not set up");

    write_time_a: assert property (stat_last_s ##0 s_q.wr |-> // [RL15]
        cs_cyc_q == 8'(({3'b000, s_q.fld[12:8]} + 8'd2) * 8'd2 - 8'd1))
        else $error("write pulse time wrong");

    rec_length_a: assert property (stat_last_s ##0 !s_q.wr |=> // [RL16]
        s_q.rec == {2'b00, $past(s_q.fld[15:13])} * 5'd4)
        else $error("recovery time after read wrong");

    full_step_a: assert property (s_q.st == mstc_pkg::ST_DRAM && !s_q.half // [RL21]
        && s_q.pulses != mstc_pkg::BURST_PULSES && s_q.idx < mstc_pkg::WAVE_BITS
        |=> s_q.idx == $past(s_q.idx) + 7'h01)
        else $error("shifter did not advance on a CPU clock");

endmodule // mstc_top
`default_nettype wire

// ==== verification/mstc_mem_model.sv ====
`default_nettype none
module mstc_mem_model (
    // Clock and trace control
    input wire logic clk_i,
    input wire logic clr_i,
    // Memory pins
    input wire logic row_strobe_n_i,
    input wire logic [3:0] column_strobe_n_i,
    // Recorded burst
    output logic [255:0] trace_o,
    output logic [8:0] row_cycles_o,
    output logic lanes_split_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Column strobe level of every cycle the row is open
    always @(posedge clk_i) begin
        if (clr_i) begin
            row_cycles_o <= 9'h0;
            lanes_split_o <= 1'b0;
        end else if (row_strobe_n_i === 1'b0) begin
            trace_o[row_cycles_o[7:0]] <= column_strobe_n_i[0];
            row_cycles_o <= row_cycles_o + 9'h1;
            if (column_strobe_n_i !== {4{column_strobe_n_i[0]}}) begin
                lanes_split_o <= 1'b1;
            end
        end
    end
endmodule // mstc_mem_model
`default_nettype wire

// ==== verification/mstc_top_tb.sv ====
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin num_errors++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module mstc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, err, strap = 1'b0, dram_req = 1'b0, dram_ack, clr = 1'b0;
    logic st_req = 1'b0, st_write = 1'b0, st_ack, st_beat, bus_width, row_n, split;
    logic [1:0] st_bank = 2'h0;
    logic [3:0] st_be = 4'h0, col_n, cs_n;
    logic [255:0] trace;
    logic [8:0] rcyc;
    int num_errors = 0;
    int comparisons = 0;
    mstc_top mstc_top_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .boot_width_pin_i(strap),
        .dram_req_i(dram_req), .dram_ack_o(dram_ack), .st_req_i(st_req), .st_bank_i(st_bank),
        .st_write_i(st_write), .st_byte_en_i(st_be), .st_ack_o(st_ack), .st_beat_o(st_beat),
        .bus_width_o(bus_width), .column_strobe_n_o(col_n), .row_strobe_n_o(row_n),
        .static_chip_select_n_o(cs_n));
    mstc_mem_model mstc_mem_model_inst (.clk_i(core_clk_i), .clr_i(clr),
        .row_strobe_n_i(row_n), .column_strobe_n_i(col_n), .trace_o(trace),
        .row_cycles_o(rcyc), .lanes_split_o(split));
    always #12.5 core_clk_i = ~core_clk_i;
    task automatic final_report;
        $display("checks %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        @(posedge core_clk_i);
        while (pready !== 1'b1) @(posedge core_clk_i);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk_i);
    endtask
    function automatic logic [15:0] fld(input logic [1:0] t, input logic [2:0] r);
        return {r, 5'h2, 5'h1, t[0], t};
    endfunction
    task automatic t_regs;
        logic [31:0] v;
        apb(1'b0, mstc_pkg::OFF_BANK_LO, 32'h0);
        `CHK("bank0 reset", mstc_pkg::BANK0_RST | 16'h0004, rd[15:0])
        apb(1'b0, 8'h1C, 32'h0);
        `CHK("unmapped", 1'b1, err)
        for (int i = 0; i < 5; i++) apb(1'b1, 8'(4 * i), 32'hA5C3_0F00 + 32'(i));
        strap <= 1'b1;
        rst_i <= 1'b1;
        repeat (16) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        for (int i = 0; i < 5; i++) begin
            v = 32'hA5C3_0F00 + 32'(i);
            if (i == 3) v[15:0] = mstc_pkg::BANK0_RST;
            apb(1'b0, 8'(4 * i), 32'h0);
            `CHK("readback", v, rd)
        end
        $display("test regs done");
    endtask
    task automatic t_dram(input logic half);
        logic [95:0] w;
        int n;
        w = '1;
        for (int j = 0; j < 8; j++) w[4+12*j+:2] = 2'b00;
        apb(1'b1, mstc_pkg::OFF_WAVE_LO, w[31:0]);
        apb(1'b1, mstc_pkg::OFF_WAVE_MID, w[63:32]);
        apb(1'b1, mstc_pkg::OFF_WAVE_HI, w[95:64]);
        apb(1'b1, mstc_pkg::OFF_DRAM_CFG, 32'(half) << 6);
        clr <= 1'b1;
        dram_req <= 1'b1;
        @(posedge core_clk_i);
        clr <= 1'b0;
        dram_req <= 1'b0;
        n = 0;
        while (dram_ack !== 1'b1 && n < 400) begin
            @(negedge core_clk_i);
            n++;
        end
        `CHK("row at ack", 1'b1, row_n)
        `CHK("lanes", 1'b0, split)
        `CHK("row cycles", 1'b1, half ? (rcyc inside {181, 182}) : rcyc == 91)
        for (int c = 0; c < (half ? 181 : 91); c++) begin
            `CHK("col trace", w[half ? c / 2 : c], trace[c])
        end
        @(posedge core_clk_i);
        $display("test dram done");
    endtask
    task automatic st_acc(input logic [1:0] b, input logic wr, input logic [3:0] be,
                          input int beats, input int first, input logic [3:0] colx);
        int n, nb, fb;
        st_req <= 1'b1;
        st_bank <= b;
        st_write <= wr;
        st_be <= be;
        @(posedge core_clk_i);
        st_req <= 1'b0;
        n = 0;
        nb = 0;
        fb = 0;
        while (st_ack !== 1'b1 && n < 500) begin
            @(negedge core_clk_i);
            n++;
            if (st_beat === 1'b1) nb++;
            if (st_beat === 1'b1 && nb == 1) fb = n;
            if (n == 1) begin
                `CHK("select", ~(4'h1 << b), cs_n)
                `CHK("col mask", colx, col_n)
                `CHK("width", b[0], bus_width)
            end
        end
        `CHK("beats", beats, nb)
        `CHK("first beat", first, fb)
        @(posedge core_clk_i);
    endtask
    task automatic gap(input logic dram, input int min);
        int n;
        n = 0;
        dram_req <= dram;
        st_req <= ~dram;
        st_bank <= 2'h3;
        st_write <= 1'b0;
        while (row_n === 1'b1 && cs_n === 4'hF && n < 500) begin
            @(negedge core_clk_i);
            n++;
        end
        @(posedge core_clk_i);
        dram_req <= 1'b0;
        st_req <= 1'b0;
        `CHK("hold-off", 1'b1, n >= min)
        n = 0;
        while (dram_ack !== 1'b1 && st_ack !== 1'b1 && n < 500) begin
            @(negedge core_clk_i);
            n++;
        end
        @(posedge core_clk_i);
    endtask
    task automatic t_static;
        apb(1'b1, mstc_pkg::OFF_BANK_LO, {fld(2'h1, 3'h0), fld(2'h0, 3'h0)});
        apb(1'b1, mstc_pkg::OFF_BANK_HI, {fld(2'h3, 3'h0), fld(2'h2, 3'h0)});
        for (int t = 0; t < 4; t++) begin
            st_acc(2'(t), 1'b0, 4'h5, t == 3 ? 8 : (t == 2 ? 4 : 1), 7, t == 1 ? 4'hA : 4'hF);
        end
        st_acc(2'h1, 1'b1, 4'h6, 1, 9, 4'h9);
        apb(1'b1, mstc_pkg::OFF_BANK_HI, {fld(2'h0, 3'h0), fld(2'h0, 3'h3)});
        st_acc(2'h2, 1'b0, 4'hF, 1, 7, 4'hF);
        gap(1'b1, 12);
        apb(1'b1, mstc_pkg::OFF_BANK_LO, {fld(2'h1, 3'h2), fld(2'h0, 3'h0)});
        st_acc(2'h1, 1'b1, 4'hF, 1, 9, 4'h0);
        gap(1'b0, 8);
        $display("test static done");
    endtask
    initial begin
        repeat (20000) @(posedge core_clk_i);
        num_errors++;
        final_report;
    end
    initial begin
        repeat (16) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        t_regs;
        t_dram(1'b0);
        t_dram(1'b1);
        t_static;
        final_report;
    end
endmodule // mstc_top_tb
`default_nettype wire
